/* File: core/irr_pkg.sv */
/*
 * Shared constants and carrier types for the infrared frame receiver.
 * Assumes a 20 MHz system clock and a synchronous active-low reset.
 */
`default_nettype none

package irr_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_NS = 50;
	localparam int TICK_US = 100;
	localparam int TICK_CYC = (TICK_US * 1000) / CLK_NS;
	localparam int INACT_MS = 10000;
	localparam int INACT_PRE_LOG2 = 13;
	localparam int INACT_PRE_CYC = 2 ** INACT_PRE_LOG2;
	// Longest interval rounds down to whole prescaled counts
	localparam longint INACT_COUNT =
		(64'(INACT_MS) * 64'd1000000) / (64'(CLK_NS) * 64'(INACT_PRE_CYC));

	// ---------------------------------------------------------------
	// Pattern widths, in ticks
	// ---------------------------------------------------------------
	localparam int WID_W = 7;
	localparam logic [6:0] END_WID = 7'h46;
	localparam logic [6:0] HDR_MIN = 7'h2a;
	localparam logic [6:0] HDR_MAX = 7'h3c;
	localparam logic [6:0] D0_MIN = 7'h07;
	localparam logic [6:0] D0_MAX = 7'h0a;
	localparam logic [6:0] D1_MIN = 7'h0e;
	localparam logic [6:0] D1_MAX = 7'h14;

	// ---------------------------------------------------------------
	// Frame layout
	// ---------------------------------------------------------------
	localparam int FRAME_BITS = 48;
	localparam logic [5:0] FRAME_LAST = 6'h2f;
	localparam logic [5:0] CMP_BITS = 6'h10;
	localparam logic [15:0] CMP_VALUE = 16'h2002;
	localparam int CODE_LSB = 32;
	localparam logic [7:0] CODE_BASE = 8'h10;
	localparam logic [7:0] CODE_LAST = 8'h17;
	localparam int N_IND = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [1:0] IRQ_LEVEL = 2'h3;

	// Receiver events, also used as enable mask
	typedef struct packed {
		logic hdr;
		logic cmp;
		logic done;
	} irr_event_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_HDR = 2'b01,
		RX_DATA = 2'b10,
		RX_TAIL = 2'b11
	} irr_rx_state_t;

	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_STOP = 2'b01,
		PWR_PARTIAL_WAKE_STATE = 2'b10
	} irr_pwr_state_t;

endpackage

`default_nettype wire

/* File: core/irr_fifo.sv */
/*
 * Frame buffer: synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`default_nettype none

module irr_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);

	localparam int AW = $clog2(DEPTH);

	// Elaboration check: the wrap-bit full test needs a power-of-two depth
	if (DEPTH < 2 || (2 ** AW) != DEPTH) begin : g_depth_check
		$error("irr_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic push;
	logic pop;

	// Full when pointers differ only in the wrap bit
	assign o_in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign o_out_valid = (wr_ptr != rd_ptr);
	assign o_out_data = mem[rd_ptr[AW-1:0]];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_ff @(posedge i_mclk) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= i_in_data;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end

endmodule

`default_nettype wire

/* File: core/irr_receiver.sv */
/*
 * Infrared remote frame receiver with indicator decode and stop/partial_wake_state control.
 * Assumes all inputs synchronous to i_mclk; the sub clock is sampled as data.
 */
// Functional notes
// RL1: Widths counted in 100 us ticks; the tick itself raises no event.
// RL2: Input filter accepts a level after three equal sub-clock samples.
// RL3: Header is 42 to 60 ticks; 70 quiet ticks end the frame.
// RL4: Bit 0 is 7 to 10 ticks, bit 1 is 14 to 20 ticks.
// RL5: Format-A reception with the input polarity inverted.
// RL6: First 16 bits equal to 0x2002 raise a compare event.
// RL7: A frame with a reception error is never stored.
// RL8: Compare, completion and header events each have an enable.
// RL9: Events leave one at a time in order, at level 3.
// RL10: A frame is one header followed by 48 data bits.
// RL11: Fifth byte 0x10+n lights indicator n+1 only; else all off.
// RL12: Inactivity timer: clock over 2^13, 10 s interval, level 3.
// RL13: No event is raised when either timer starts counting.
// RL14: Stop-to-partial_wake_state switching is disabled in normal operation.
// RL15: After 10 s idle, enable partial_wake_state then enter stop.
// RL16: In stop, input makes the receiver work in partial_wake_state, core asleep.
// RL17: An event raised during partial_wake_state returns to normal operation.
// RL18: Every completed frame restarts the inactivity timer.
// RL19: Indicators off at reset, never more than one lit.
`default_nettype none

module irr_receiver #(
	parameter longint INACT_COUNT = irr_pkg::INACT_COUNT,
	parameter int FIFO_DEPTH = irr_pkg::FIFO_DEPTH,
	parameter int TICK_CYC = irr_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Link pins
	input wire logic i_remote_in,
	input wire logic i_low_speed_sub_clock,
	// Configuration
	input wire irr_pkg::irr_event_t i_irq_en,
	// Frame stream
	input wire logic i_frame_ready,
	output logic o_frame_valid,
	output logic [irr_pkg::FRAME_BITS-1:0] o_frame,
	// Events and status
	output logic o_irq,
	output irr_pkg::irr_event_t o_irq_cause,
	output logic [1:0] o_irq_level,
	output logic o_rx_error,
	output logic o_overrun,
	output logic o_inactivity_timer_irq,
	output logic o_core_stop,
	output logic o_partial_wake_state,
	output logic [irr_pkg::N_IND-1:0] o_indicator
);

	// Elaboration checks; a tick under nine cycles leaves the filter no room
	if (INACT_COUNT < 1 || INACT_COUNT > 64'd16777215) begin : g_inact_check
		$error("irr_receiver: INACT_COUNT out of range");
	end
	if (TICK_CYC < 9 || TICK_CYC > 4096) begin : g_tick_check
		$error("irr_receiver: TICK_CYC out of range");
	end

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	function automatic logic in_range(input logic [6:0] w, input logic [6:0] lo,
		input logic [6:0] hi);
		in_range = (w >= lo) && (w <= hi);
	endfunction

	function automatic logic [irr_pkg::N_IND-1:0] ind_decode(input logic [7:0] code);
		logic [7:0] idx;
		idx = code - irr_pkg::CODE_BASE;
		ind_decode = '0;
		if (code >= irr_pkg::CODE_BASE && code <= irr_pkg::CODE_LAST)
			ind_decode[idx[2:0]] = 1'b1;
	endfunction

	// ---------------------------------------------------------------
	// Tick generator and noise filter
	// ---------------------------------------------------------------
	logic [11:0] tick_cnt;
	logic tick;
	logic sub_q;
	logic [2:0] samp;
	logic level;
	logic level_q;
	logic rise;

	// RL1: 100 us tick
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == 12'(TICK_CYC - 1));
			tick_cnt <= (tick_cnt == 12'(TICK_CYC - 1)) ? '0 : tick_cnt + 1'b1;
		end
	end

	// RL2: three-sample filter
	// RL5: inverted polarity
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			sub_q <= 1'b0;
			samp <= '0;
			level <= 1'b0;
			level_q <= 1'b0;
		end else begin
			sub_q <= i_low_speed_sub_clock;
			level_q <= level;
			if (i_low_speed_sub_clock && !sub_q)
				samp <= {samp[1:0], !i_remote_in};
			if (samp == 3'b111)
				level <= 1'b1;
			else if (samp == 3'b000)
				level <= 1'b0;
		end
	end

	assign rise = level && !level_q;

	// ---------------------------------------------------------------
	// Pattern receiver
	// ---------------------------------------------------------------
	irr_pkg::irr_rx_state_t rx_state;
	irr_pkg::irr_pwr_state_t pwr_state;
	logic [6:0] width;
	logic [5:0] bit_cnt;
	logic [irr_pkg::FRAME_BITS-1:0] shreg;
	irr_pkg::irr_event_t ev;
	logic rx_err;
	logic rx_on;
	logic timeout;
	logic push;
	logic fifo_in_ready;
	logic partial_wake_state_en;

	assign timeout = (width == irr_pkg::END_WID);
	// RL16: a mark seen in stop starts reception without the core
	assign rx_on = (pwr_state != irr_pkg::PWR_STOP) || (partial_wake_state_en && rise);

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			width <= '0;
		else if (rise)
			width <= '0;
		else if (tick && !timeout)
			width <= width + 1'b1;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rx_state <= irr_pkg::RX_IDLE;
			bit_cnt <= '0;
			shreg <= '0;
			ev <= '0;
			rx_err <= 1'b0;
			push <= 1'b0;
		end else begin
			ev <= '0;
			rx_err <= 1'b0;
			push <= 1'b0;
			if (rx_on) begin
				unique case (rx_state)
					irr_pkg::RX_IDLE: begin
						if (rise)
							rx_state <= irr_pkg::RX_HDR;
					end
					irr_pkg::RX_HDR: begin
						// RL3: header window
						if (rise && in_range(width, irr_pkg::HDR_MIN, irr_pkg::HDR_MAX)) begin
							ev.hdr <= 1'b1;
							bit_cnt <= '0;
							rx_state <= irr_pkg::RX_DATA;
						end else if (timeout)
							rx_state <= irr_pkg::RX_IDLE;
					end
					irr_pkg::RX_DATA: begin
						if (rise) begin
							// RL4: bit classification
							if (in_range(width, irr_pkg::D0_MIN, irr_pkg::D0_MAX) ||
								in_range(width, irr_pkg::D1_MIN, irr_pkg::D1_MAX)) begin
								shreg[bit_cnt] <= (width >= irr_pkg::D1_MIN);
								bit_cnt <= bit_cnt + 1'b1;
								// RL10: 48 bits then trailer
								if (bit_cnt == irr_pkg::FRAME_LAST)
									rx_state <= irr_pkg::RX_TAIL;
							end else begin
								rx_err <= 1'b1;
								rx_state <= irr_pkg::RX_IDLE;
							end
						end else if (timeout) begin
							rx_err <= 1'b1;
							rx_state <= irr_pkg::RX_IDLE;
						end
						// RL6: compare after 16 bits
						if (bit_cnt == irr_pkg::CMP_BITS && $past(bit_cnt) != bit_cnt &&
							shreg[15:0] == irr_pkg::CMP_VALUE)
							ev.cmp <= 1'b1;
					end
					irr_pkg::RX_TAIL: begin
						// RL3: quiet end of frame
						// RL7: only an error-free frame is pushed
						if (timeout) begin
							ev.done <= 1'b1;
							push <= 1'b1;
							rx_state <= irr_pkg::RX_IDLE;
						end else if (rise) begin
							rx_err <= 1'b1;
							rx_state <= irr_pkg::RX_HDR;
						end
					end
				endcase
			end
		end
	end

	// Enable mask applied before delivery
	irr_pkg::irr_event_t ev_gated;
	assign ev_gated = ev & i_irq_en;

	// ---------------------------------------------------------------
	// Frame buffer and indicators
	// ---------------------------------------------------------------
	logic fifo_out_valid;
	logic [irr_pkg::FRAME_BITS-1:0] fifo_out_data;
	logic pop;

	assign pop = fifo_out_valid && i_frame_ready;

	irr_fifo #(
		.WIDTH(irr_pkg::FRAME_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_in_valid(push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(shreg),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(i_frame_ready),
		.o_out_data(fifo_out_data)
	);

	// RL19: cleared at reset, one-hot at most
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_frame_valid <= 1'b0;
			o_frame <= '0;
			o_indicator <= '0;
			o_overrun <= 1'b0;
		end else begin
			o_frame_valid <= pop;
			o_overrun <= push && !fifo_in_ready;
			if (pop) begin
				o_frame <= fifo_out_data;
				// RL11: fifth byte selects indicator
				o_indicator <= ind_decode(fifo_out_data[irr_pkg::CODE_LSB +: 8]);
			end
		end
	end

	// ---------------------------------------------------------------
	// Event delivery
	// ---------------------------------------------------------------
	// RL8: per-event enables
	// RL9: events never coincide, so each leaves alone
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
			o_irq_cause <= '0;
			o_irq_level <= '0;
			o_rx_error <= 1'b0;
		end else begin
			o_irq <= |ev_gated;
			o_irq_cause <= ev_gated;
			o_irq_level <= irr_pkg::IRQ_LEVEL;
			o_rx_error <= rx_err;
		end
	end

	// ---------------------------------------------------------------
	// Inactivity timer and power states
	// ---------------------------------------------------------------
	logic [12:0] pre_cnt;
	logic [23:0] inact_cnt;
	logic expire;

	// RL12: prescale by 2^13, 10 s interval
	// RL13: expiry only at end of interval, not at start
	assign expire = (pre_cnt == 13'h1fff) && (inact_cnt == 24'(INACT_COUNT - 1));

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pre_cnt <= '0;
			inact_cnt <= '0;
		end else if (pwr_state != irr_pkg::PWR_RUN || ev.done) begin
			// RL18: completed frame restarts the interval
			pre_cnt <= '0;
			inact_cnt <= '0;
		end else begin
			pre_cnt <= pre_cnt + 1'b1;
			if (pre_cnt == 13'h1fff)
				inact_cnt <= expire ? '0 : inact_cnt + 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pwr_state <= irr_pkg::PWR_RUN;
			partial_wake_state_en <= 1'b0;
			o_inactivity_timer_irq <= 1'b0;
		end else begin
			o_inactivity_timer_irq <= expire && pwr_state == irr_pkg::PWR_RUN;
			unique case (pwr_state)
				irr_pkg::PWR_RUN: begin
					// RL14: switching disabled while running
					// RL15: arm partial_wake_state, then stop
					partial_wake_state_en <= expire;
					if (expire)
						pwr_state <= irr_pkg::PWR_STOP;
				end
				irr_pkg::PWR_STOP: begin
					// RL16: mark starts partial_wake_state reception
					if (partial_wake_state_en && rise)
						pwr_state <= irr_pkg::PWR_PARTIAL_WAKE_STATE;
				end
				irr_pkg::PWR_PARTIAL_WAKE_STATE: begin
					// RL17: raised event wakes the core
					if (|ev_gated) begin
						pwr_state <= irr_pkg::PWR_RUN;
						partial_wake_state_en <= 1'b0;
					end else if (rx_err)
						pwr_state <= irr_pkg::PWR_STOP;
				end
				default: pwr_state <= irr_pkg::PWR_RUN;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_core_stop <= 1'b0;
			o_partial_wake_state <= 1'b0;
		end else begin
			o_core_stop <= (pwr_state == irr_pkg::PWR_STOP);
			o_partial_wake_state <= (pwr_state == irr_pkg::PWR_PARTIAL_WAKE_STATE);
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	sequence s_expire_run;
		expire && pwr_state == irr_pkg::PWR_RUN;
	endsequence
	sequence s_stop_armed;
		pwr_state == irr_pkg::PWR_STOP && partial_wake_state_en;
	endsequence

	tick_spacing_a: assert property (tick |=> !tick [*8]) // RL1
		else $error("tick came too soon");
	filter_three_a: assert property ($rose(level) |-> $past(samp) == 3'b111) // RL2
		else $error("level rose without three samples");
	header_window_a: assert property (ev.hdr |-> // RL3
		$past(width) >= 7'd42 && $past(width) <= 7'd60)
		else $error("header width outside window");
	compare_value_a: assert property (ev.cmp |-> shreg[15:0] == 16'h2002) // RL6
		else $error("compare event on wrong value");
	error_no_store_a: assert property (rx_err |-> !push) // RL7
		else $error("errored frame stored");
	irq_order_a: assert property (|ev_gated |=> o_irq && o_irq_cause == $past(ev_gated)) // RL9
		else $error("event not delivered next cycle");
	frame_length_a: assert property (ev.done |-> $past(bit_cnt) == 6'd48) // RL10
		else $error("frame done with wrong bit count");
	indicator_code_a: assert property (pop && fifo_out_data[39:32] == 8'h13 |=> // RL11
		o_indicator == 8'h08)
		else $error("indicator decode wrong");
	indicator_onehot_a: assert property ($onehot0(o_indicator)) // RL19
		else $error("more than one indicator lit");
	run_no_partial_wake_state_a: assert property (pwr_state == irr_pkg::PWR_RUN |-> !partial_wake_state_en) // RL14
		else $error("partial_wake_state armed while running");
	stop_entry_a: assert property (s_expire_run |=> s_stop_armed ##1 o_core_stop) // RL15
		else $error("stop entry sequence broken");
	partial_wake_state_wake_a: assert property (pwr_state == irr_pkg::PWR_PARTIAL_WAKE_STATE && |ev_gated |=> // RL17
		pwr_state == irr_pkg::PWR_RUN ##1 !o_partial_wake_state)
		else $error("partial_wake_state did not return to run");
	restart_a: assert property (ev.done && pwr_state == irr_pkg::PWR_RUN |=> // RL18
		inact_cnt == 24'h0 && pre_cnt == 13'h0)
		else $error("frame did not restart timer");

endmodule

`default_nettype wire

/* File: verif/irr_tx_model.sv */
/*
 * Model of the remote transmitter seen through the receiver module.
 * Assumes a 20 MHz i_mclk; the line idles high (pull-up) and is low in a mark.
 */
`default_nettype none

module irr_tx_model #(
	parameter int TICK_CYC = irr_pkg::TICK_CYC,
	parameter int SUB_HALF = 305
) (
	// Clock
	input wire logic i_mclk,
	// Link pins
	output logic o_remote,
	output logic o_sub_clk
);
	timeunit 1ns;
	timeprecision 1ps;

	int sub_cnt = 0;

	initial begin
		o_remote = 1'b1;
		o_sub_clk = 1'b0;
	end

	// Slow clock runs free, as an oscillator would; near 32 kHz at the default
	always @(posedge i_mclk) begin
		sub_cnt <= (sub_cnt == SUB_HALF - 1) ? 0 : sub_cnt + 1;
		if (sub_cnt == SUB_HALF - 1) begin
			o_sub_clk <= ~o_sub_clk;
		end
	end

	// One mark then one space, in ticks; entered just after a clock edge
	task automatic burst(input int mark_t, input int space_t);
		o_remote <= 1'b0;
		repeat (mark_t * TICK_CYC) @(posedge i_mclk);
		o_remote <= 1'b1;
		repeat (space_t * TICK_CYC) @(posedge i_mclk);
	endtask

	// header then bits
	// Bits go out first bit first; a bad bit of 12 ticks cuts the frame short
	task automatic send_frame(input logic [47:0] data, input int bad_bit);
		burst(32, 16);
		for (int i = 0; i < irr_pkg::FRAME_BITS; i++) begin
			if (i == bad_bit) begin
				burst(2, 10);
				break;
			end
			burst(2, data[i] ? 14 : 6);
		end
		// Quiet just past the 70-tick end, so the done event lands inside the frame
		burst(2, 72);
	endtask
endmodule

`default_nettype wire

/* File: verif/irr_receiver_bench.sv */
/*
 * Self-checking bench for the infrared frame receiver.
 * Assumes the transmitter model irr_tx_model and the design under core/.
 */
`default_nettype none

module irr_receiver_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// Setup
	// ---------------------------------------------------------------
	// Short tick, short stop interval and shallow buffer keep the run near 100k cycles
	localparam longint INACT = 2;
	localparam int DEPTH = 2;
	localparam int TICK = 9;
	localparam longint STOP_CYC = irr_pkg::INACT_PRE_CYC * INACT;
	localparam longint LIMIT = 120000;

	typedef struct packed {
		logic [47:0] frame;
		logic [7:0] ind;
	} irr_exp_t;

	logic i_mclk, i_rst_n, i_frame_ready;
	irr_pkg::irr_event_t i_irq_en, o_irq_cause;
	wire logic remote, sub_clk;
	logic o_frame_valid, o_irq, o_rx_error, o_overrun;
	logic o_inactivity_timer_irq, o_core_stop, o_partial_wake_state;
	logic [47:0] o_frame;
	logic [1:0] o_irq_level;
	logic [7:0] o_indicator;
	irr_exp_t frame_q[$];
	logic [2:0] ev_q[$];
	irr_exp_t got;
	logic [2:0] want;
	int miscompares = 0;
	int n_tests = 0;
	int n_over = 0;
	longint cyc = 0;
	longint last_done = 0;
	logic armed = 1'b0;
	logic saw_partial_wake_state = 1'b0;

	irr_tx_model #(.TICK_CYC(TICK), .SUB_HALF(1)) u_irr_tx_model (.i_mclk(i_mclk),
		.o_remote(remote), .o_sub_clk(sub_clk));

	irr_receiver #(.INACT_COUNT(INACT), .FIFO_DEPTH(DEPTH), .TICK_CYC(TICK)) u_irr_receiver (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_remote_in(remote),
		.i_low_speed_sub_clock(sub_clk), .i_irq_en(i_irq_en), .i_frame_ready(i_frame_ready),
		.o_frame_valid(o_frame_valid), .o_frame(o_frame), .o_irq(o_irq),
		.o_irq_cause(o_irq_cause), .o_irq_level(o_irq_level), .o_rx_error(o_rx_error),
		.o_overrun(o_overrun), .o_inactivity_timer_irq(o_inactivity_timer_irq),
		.o_core_stop(o_core_stop), .o_partial_wake_state(o_partial_wake_state),
		.o_indicator(o_indicator));

	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask

	task automatic final_report();
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Notes the expected events and frame, then has the model send it
	task automatic send(input logic [7:0] code, input logic [15:0] id, input int bad,
			input logic keep, input irr_pkg::irr_event_t en);
		logic [47:0] d;
		irr_exp_t e;
		d = {8'($urandom()), code, 16'($urandom()), id};
		e.frame = d;
		e.ind = (code >= 8'h10 && code <= 8'h17) ? (8'h01 << code[2:0]) : 8'h00;
		// Masked events are not expected; an error is never masked
		if (en.hdr) begin
			ev_q.push_back(3'b100);
		end
		if (en.cmp && id == 16'h2002 && (bad < 0 || bad >= 16)) begin
			ev_q.push_back(3'b010);
		end
		if (bad >= 0) begin
			ev_q.push_back(3'b000);
		end else if (en.done) begin
			ev_q.push_back(3'b001);
		end
		if (bad < 0 && keep) begin
			frame_q.push_back(e);
		end
		@(posedge i_mclk);
		i_irq_en <= en;
		u_irr_tx_model.send_frame(d, bad);
	endtask

	// ---------------------------------------------------------------
	// Output watcher
	// ---------------------------------------------------------------
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			miscompares++;
			final_report();
		end
		if (i_rst_n === 1'b1) begin
			check(!$isunknown(o_indicator) && $onehot0(o_indicator), "indicators");
			if (o_frame_valid === 1'b1) begin
				got = (frame_q.size() > 0) ? frame_q.pop_front() : 56'h0;
				check(o_frame === got.frame, "frame data");
				check(o_indicator === got.ind, "indicator pattern");
			end
			if (o_irq === 1'b1 || o_rx_error === 1'b1) begin
				want = (ev_q.size() > 0) ? ev_q.pop_front() : 3'b111;
				check(o_irq ? o_irq_cause === want : want === 3'b000, "event order");
				check(o_irq_level === 2'h3, "event level");
			end
			if (o_irq === 1'b1 && o_irq_cause.done === 1'b1) begin
				last_done <= cyc;
			end
			if (o_overrun === 1'b1) begin
				n_over++;
			end
			if (o_partial_wake_state === 1'b1) begin
				saw_partial_wake_state <= 1'b1;
			end
			if (o_inactivity_timer_irq === 1'b1) begin
				check(armed && cyc - last_done >= STOP_CYC - 4
					&& cyc - last_done <= STOP_CYC + 4, "stop timer");
			end
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		i_rst_n <= 1'b0;
		i_frame_ready <= 1'b0;
		i_irq_en <= 3'b111;
		void'($urandom(25345));
		repeat (16) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_frame_ready <= 1'b1;
		#1;
		check(o_indicator === 8'h00 && o_irq_level === 2'h3, "reset state");
		// Every channel code, then one foreign code with a wrong compare field
		// The foreign frame runs with header and done events masked
		for (int n = 0; n < 9; n++) begin
			send(8'h10 + 8'(n), n < 8 ? 16'h2002 : 16'h2003, -1, 1'b1,
				n < 8 ? 3'b111 : 3'b010);
		end
		send(8'h12, 16'h2002, 20, 1'b1, 3'b111);
		// Consumer stalls while three frames arrive for two places
		i_frame_ready <= 1'b0;
		for (int n = 0; n < 3; n++) begin
			send(8'h15, 16'h2002, -1, n < DEPTH, 3'b111);
		end
		check(n_over == 1 && o_frame_valid === 1'b0, "buffer full");
		i_frame_ready <= 1'b1;
		repeat (8) @(posedge i_mclk);
		check(frame_q.size() == 0, "buffer drained");
		armed = 1'b1;
		for (longint i = 0; i < STOP_CYC + 100 && o_core_stop !== 1'b1; i++) begin
			@(posedge i_mclk);
		end
		check(o_core_stop === 1'b1, "stop entered");
		send(8'h17, 16'h2002, -1, 1'b1, 3'b111);
		check(saw_partial_wake_state && o_core_stop === 1'b0 && o_partial_wake_state === 1'b0, "woken");
		repeat (8) @(posedge i_mclk);
		check(frame_q.size() == 0 && ev_q.size() == 0, "all results seen");
		final_report();
	end
endmodule

`default_nettype wire
